/* src/fmg_guard.sv */
`timescale 1ns/1ns
// Function
// RQ1 - identity byte at fixed flash address readable, value names variant
// RQ2 - modify with monitor or its reset source off causes error reset
// RQ3 - power-on reset enables monitor and its reset-source selection
// RQ4 - software disables interrupts around program write enable
// RQ5 - interrupts raised during flash modify stay pending until done
// RQ6 - software sets write enables in exactly one routine each
// RQ7 - software writes reset source register whole, power-on flag set
// RQ8 - software re-enables monitor after write enable, before modify
// RQ9 - software runs from internal oscillator while modifying flash
// RQ10 - sense-amp enable one-shot pulse per flash access cycle
// RQ11 - one-shot active after reset, bypass bit one bypasses it
// RQ12 - software bypasses one-shot above frequency threshold
// RQ13 - flash organised in 64-byte rows, row change flagged
// RQ14 - pending interrupt wakes idle mode within three cycles
// RQ15 - software bounds-checks flash modify addresses
// RQ16 - byte write needs write enable, erase also needs erase enable
// RQ17 - error reset cause reads as flash error flag one
// RQ18 - guard checked at modify issue, array untouched on reset
module fmg_guard
   import fmg_pkg::*;
#(
   parameter int AW = FMG_ADDR_W,
   parameter int ERASE_CYCLES = 512,
   parameter logic [7:0] ID_VALUE = FMG_ID_DEFAULT
)
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic por_i,
   // control bits
   input wire logic program_write_enable_i,
   input wire logic page_erase_enable_i,
   input wire logic bypass_i,
   input wire logic vmon_en_wr_i,
   input wire logic vmon_en_i,
   input wire logic vmon_rst_en_i,
   input wire logic flag_clr_i,
   // flash access
   input wire logic mod_req_i,
   input wire logic [AW-1:0] mod_addr_i,
   input wire logic [7:0] mod_data_i,
   input wire logic rd_req_i,
   input wire logic [AW-1:0] rd_addr_i,
   // interrupts and idle
   input wire logic irq_i,
   input wire logic irq_en_i,
   input wire logic idle_req_i,
   // outputs
   output logic [7:0] rd_data_o,
   output logic busy_o,
   output logic flash_error_reset_o,
   output logic flash_error_flag_o,
   output logic power_on_flag_o,
   output logic vmon_en_o,
   output logic vmon_rst_en_o,
   output logic sense_en_o,
   output logic row_change_o,
   output logic irq_pending_o,
   output logic irq_take_o,
   output logic idle_o
);
   initial
   begin
      if (AW < FMG_PAGE_LSB + 1 || AW > 16 || ERASE_CYCLES < (1 << FMG_PAGE_LSB))
      begin
         $error("fmg_guard: unsupported parameters");
      end
   end

   typedef enum logic [2:0] {
      FMG_IDLE = 3'b001,
      FMG_ERASE = 3'b010,
      FMG_WRITE = 3'b100
   } fmg_state_e;

   localparam int CW = $clog2(ERASE_CYCLES + 1);

   fmg_mem_if #(.AW(AW), .DW(8)) mif ();
   fmg_flash_mem #(.AW(AW), .ID_VALUE(ID_VALUE)) u_mem (
      .clk_sys_i(clk_sys_i),
      .port(mif.ctrl)
   );

   function automatic logic [AW-FMG_ROW_LSB-1:0] row_of(input logic [AW-1:0] a);
      return a[AW-1:FMG_ROW_LSB];
   endfunction

   fmg_state_e state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic [7:0] data_reg, data_next;
   logic vmon_reg, vmon_next, vrst_reg, vrst_next;
   logic ferr_reg, ferr_next, por_flag_reg, por_flag_next;
   logic fer_reg, fer_next;
   logic busy_reg, busy_next;
   logic we_reg, we_next;
   logic bypass_reg, bypass_next;
   logic [1:0] shot_reg, shot_next;
   logic sense_reg, sense_next;
   logic [AW-FMG_ROW_LSB-1:0] row_reg, row_next;
   logic rowc_reg, rowc_next;
   logic pend_reg, pend_next, take_reg, take_next;
   logic idle_reg, idle_next;
   logic [1:0] wake_reg, wake_next;
   logic guard_ok;

   assign guard_ok = vmon_reg && vrst_reg; // RQ2 RQ18

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      vmon_next = vmon_en_wr_i ? vmon_en_i : vmon_reg;
      vrst_next = vmon_en_wr_i ? vmon_rst_en_i : vrst_reg;
      ferr_next = flag_clr_i ? 1'b0 : ferr_reg;
      por_flag_next = flag_clr_i ? 1'b0 : por_flag_reg;
      fer_next = 1'b0;
      we_next = 1'b0;
      if (por_i)
      begin
         vmon_next = 1'b1; // RQ3
         vrst_next = 1'b1; // RQ3
         por_flag_next = 1'b1;
      end
      case (state_reg)
         FMG_IDLE:
         begin
            if (mod_req_i && program_write_enable_i) // RQ16
            begin
               if (!guard_ok)
               begin
                  fer_next = 1'b1; // RQ2 RQ18
                  ferr_next = 1'b1; // RQ17
               end
               else if (page_erase_enable_i) // RQ16
               begin
                  state_next = FMG_ERASE;
                  addr_next = {mod_addr_i[AW-1:FMG_PAGE_LSB], {FMG_PAGE_LSB{1'b0}}};
                  data_next = FMG_ERASED;
                  cnt_next = CW'(ERASE_CYCLES);
               end
               else
               begin
                  state_next = FMG_WRITE;
                  addr_next = mod_addr_i;
                  data_next = mod_data_i;
               end
            end
         end
         FMG_ERASE:
         begin
            we_next = 1'b1;
            data_next = FMG_ERASED;
            // sweep wraps inside the page
            addr_next = {addr_reg[AW-1:FMG_PAGE_LSB],
               FMG_PAGE_LSB'(addr_reg[FMG_PAGE_LSB-1:0] + 1'b1)};
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == CW'(1))
            begin
               state_next = FMG_IDLE;
            end
         end
         FMG_WRITE:
         begin
            we_next = 1'b1;
            state_next = FMG_IDLE;
         end
         default:
         begin
            state_next = FMG_IDLE;
         end
      endcase
      busy_next = (state_next != FMG_IDLE);
      // strobe aligned with the write or erase state
      we_next = (state_next != FMG_IDLE);
   end

   // write path reads old byte so bits only clear
   assign mif.raddr = (state_reg == FMG_IDLE && mod_req_i) ? mod_addr_i : rd_addr_i;
   assign mif.we = we_reg;
   assign mif.waddr = addr_reg;
   assign mif.wdata = (state_reg == FMG_WRITE) ? (data_reg & mif.rdata) : data_reg;

   always_comb
   begin
      bypass_next = bypass_i; // RQ11
      shot_next = 2'h0;
      sense_next = 1'b0;
      row_next = row_reg;
      rowc_next = 1'b0;
      if (rd_req_i)
      begin
         shot_next = bypass_reg ? 2'h0 : 2'(FMG_SENSE_CYC); // RQ10
         sense_next = 1'b1; // RQ10
         row_next = row_of(rd_addr_i); // RQ13
         rowc_next = (row_of(rd_addr_i) != row_reg); // RQ13
      end
      else if (bypass_reg)
      begin
         sense_next = sense_reg;
      end
      else if (shot_reg > 2'h1)
      begin
         shot_next = shot_reg - 2'h1;
         sense_next = 1'b1;
      end
      pend_next = (pend_reg || irq_i) && !take_reg; // RQ5
      take_next = pend_reg && irq_en_i && !busy_reg && !take_reg; // RQ5
      idle_next = idle_reg;
      wake_next = 2'h0;
      if (!idle_reg && idle_req_i)
      begin
         idle_next = 1'b1;
      end
      else if (idle_reg && (pend_reg || irq_i))
      begin
         wake_next = wake_reg + 2'h1;
         if (wake_reg == 2'(FMG_WAKE_CYCLES - 2))
         begin
            idle_next = 1'b0; // RQ14
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= FMG_IDLE;
         cnt_reg <= '0;
         addr_reg <= '0;
         data_reg <= 8'h00;
         vmon_reg <= FMG_VMON_RST;
         vrst_reg <= FMG_VMON_RST;
         ferr_reg <= 1'b0;
         por_flag_reg <= 1'b0;
         fer_reg <= 1'b0;
         busy_reg <= 1'b0;
         we_reg <= 1'b0;
         bypass_reg <= FMG_BYPASS_RST;
         shot_reg <= 2'h0;
         sense_reg <= 1'b0;
         row_reg <= '0;
         rowc_reg <= 1'b0;
         pend_reg <= 1'b0;
         take_reg <= 1'b0;
         idle_reg <= 1'b0;
         wake_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         vmon_reg <= vmon_next;
         vrst_reg <= vrst_next;
         ferr_reg <= ferr_next;
         por_flag_reg <= por_flag_next;
         fer_reg <= fer_next;
         busy_reg <= busy_next;
         we_reg <= we_next;
         bypass_reg <= bypass_next;
         shot_reg <= shot_next;
         sense_reg <= sense_next;
         row_reg <= row_next;
         rowc_reg <= rowc_next;
         pend_reg <= pend_next;
         take_reg <= take_next;
         idle_reg <= idle_next;
         wake_reg <= wake_next;
      end
   end

   logic [7:0] rd_reg;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rd_reg <= 8'h00;
      end
      else
      begin
         rd_reg <= mif.rdata; // RQ1
      end
   end

   assign rd_data_o = rd_reg;
   assign busy_o = busy_reg;
   assign flash_error_reset_o = fer_reg;
   assign flash_error_flag_o = ferr_reg;
   assign power_on_flag_o = por_flag_reg;
   assign vmon_en_o = vmon_reg;
   assign vmon_rst_en_o = vrst_reg;
   assign sense_en_o = sense_reg;
   assign row_change_o = rowc_reg;
   assign irq_pending_o = pend_reg;
   assign irq_take_o = take_reg;
   assign idle_o = idle_reg;
endmodule

/* inc/fmg_pkg.sv */
package fmg_pkg;
   localparam int FMG_ADDR_W = 14;
   localparam int FMG_DATA_W = 8;
   localparam logic [13:0] FMG_ID_ADDR = 14'h3FFE;
   // arbitrary neutral identity value
   localparam logic [7:0] FMG_ID_DEFAULT = 8'h5A;
   localparam int FMG_ROW_BYTES = 64;
   localparam int FMG_ROW_LSB = 6;
   localparam int FMG_PAGE_LSB = 9;
   localparam logic [7:0] FMG_ERASED = 8'hFF;
   localparam int FMG_PSC_WE_BIT = 0;
   localparam int FMG_PSC_EE_BIT = 1;
   localparam logic [2:0] FMG_PSC_RST = 3'h0;
   localparam logic FMG_BYPASS_RST = 1'b0;
   localparam logic FMG_VMON_RST = 1'b1;
   localparam int FMG_WAKE_CYCLES = 3;
   localparam int FMG_CLK_HZ = 50000000;
   localparam int FMG_SENSE_NS = 20;
   localparam int FMG_SENSE_CYC = (FMG_SENSE_NS * (FMG_CLK_HZ / 1000000) + 999) / 1000;
endpackage

/* inc/fmg_mem_if.sv */
`timescale 1ns/1ns
interface fmg_mem_if #(parameter int AW = 14, parameter int DW = 8);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* src/fmg_flash_mem.sv */
`timescale 1ns/1ns
module fmg_flash_mem
   import fmg_pkg::*;
#(
   parameter int AW = 14,
   parameter logic [7:0] ID_VALUE = FMG_ID_DEFAULT
)
(
   input wire logic clk_sys_i,
   fmg_mem_if.mem port
);
   logic [7:0] mem_reg [0:(1<<AW)-1];
   logic [7:0] rdata_reg;
   // erased array, identity byte preset
   initial
   begin
      for (int i = 0; i < (1<<AW); i++)
      begin
         mem_reg[i] = (i == int'(FMG_ID_ADDR)) ? ID_VALUE : FMG_ERASED;
      end
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (port.we)
      begin
         mem_reg[port.waddr] <= port.wdata;
      end
      rdata_reg <= mem_reg[port.raddr];
   end
   assign port.rdata = rdata_reg;
endmodule

/* sim/fmg_guard_chk.sv */
`timescale 1ns/1ns
module fmg_guard_chk
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic por_i,
   // controls
   input wire logic program_write_enable_i,
   input wire logic page_erase_enable_i,
   input wire logic bypass_i,
   input wire logic mod_req_i,
   input wire logic rd_req_i,
   input wire logic irq_i,
   // outputs watched
   input wire logic busy_o,
   input wire logic flash_error_reset_o,
   input wire logic flash_error_flag_o,
   input wire logic power_on_flag_o,
   input wire logic vmon_en_o,
   input wire logic vmon_rst_en_o,
   input wire logic sense_en_o,
   input wire logic irq_pending_o,
   input wire logic irq_take_o,
   input wire logic idle_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   sequence mod_take_s;
      mod_req_i && !busy_o && program_write_enable_i;
   endsequence
   sequence write_done_s;
      busy_o ##1 !busy_o;
   endsequence
   guard_reset_a: assert property (mod_take_s ##0 !(vmon_en_o && vmon_rst_en_o)
      |=> flash_error_reset_o && !busy_o) else $error("guard reset missing");
   error_flag_a: assert property (flash_error_reset_o |-> flash_error_flag_o)
      else $error("error flag not set");
   byte_write_a: assert property (mod_take_s ##0 (vmon_en_o && vmon_rst_en_o &&
      !page_erase_enable_i) |=> write_done_s) else $error("write busy wrong");
   write_off_a: assert property (mod_req_i && !program_write_enable_i |=>
      !busy_o && !flash_error_reset_o) else $error("write without enable");
   por_enable_a: assert property (por_i |=> vmon_en_o && vmon_rst_en_o &&
      power_on_flag_o) else $error("power-on enables missing");
   sense_pulse_a: assert property (rd_req_i |=> sense_en_o)
      else $error("sense enable missing");
   one_shot_a: assert property (!rd_req_i && !bypass_i && !$past(bypass_i)
      |=> !sense_en_o) else $error("sense enable not one-shot");
   irq_hold_a: assert property (irq_pending_o && busy_o |=> !irq_take_o)
      else $error("interrupt taken while busy");
   irq_pend_a: assert property (irq_i |=> irq_pending_o)
      else $error("interrupt not pending");
   idle_wake_a: assert property (idle_o && irq_i |-> ##[1:3] !idle_o)
      else $error("idle wake too slow");
endmodule
bind fmg_guard fmg_guard_chk chk (.*);

/* sim/flash_modify_guard_read_power_bench.sv */
`timescale 1ns/1ns
module flash_modify_guard_read_power_bench;
   import fmg_pkg::*;
   localparam int EC = 512;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic por_i = 0, program_write_enable_i = 0, page_erase_enable_i = 0, bypass_i = 0;
   logic vmon_en_wr_i = 0, vmon_en_i = 1, vmon_rst_en_i = 1, flag_clr_i = 0;
   logic mod_req_i = 0, rd_req_i = 0, irq_i = 0, irq_en_i = 1, idle_req_i = 0;
   logic [13:0] mod_addr_i = '0, rd_addr_i = '0;
   logic [7:0] mod_data_i = '0, rd_data_o;
   logic busy_o, flash_error_reset_o, flash_error_flag_o, power_on_flag_o, vmon_en_o;
   logic vmon_rst_en_o, sense_en_o, row_change_o, irq_pending_o, irq_take_o, idle_o;
   logic err_seen, take_busy;
   int failures = 0, samples_checked = 0, nbusy;
   fmg_guard #(.ERASE_CYCLES(EC)) dut (.*);
   always #10 clk_sys_i = ~clk_sys_i;
   function automatic logic [7:0] exp_and(input logic [7:0] x, input logic [7:0] y);
      return FMG_ERASED & x & y;
   endfunction
   task tick;
      @(posedge clk_sys_i);
      #2;
   endtask
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task rd(input logic [13:0] a, output logic [7:0] d, output logic rc);
      rd_addr_i = a;
      rd_req_i = 1;
      tick;
      rd_req_i = 0;
      rc = row_change_o;
      tick;
      d = rd_data_o;
   endtask
   task md(input logic [13:0] a, input logic [7:0] v, input logic q);
      mod_addr_i = a;
      mod_data_i = v;
      mod_req_i = 1;
      irq_i = q;
      tick;
      mod_req_i = 0;
      irq_i = 0;
      err_seen = flash_error_reset_o;
      nbusy = 0;
      take_busy = 0;
      while (busy_o === 1'b1 && nbusy < EC + 50)
      begin
         take_busy |= irq_take_o;
         nbusy++;
         tick;
      end
   endtask
   task vm(input logic e, input logic r);
      vmon_en_i = e;
      vmon_rst_en_i = r;
      vmon_en_wr_i = 1;
      tick;
      vmon_en_wr_i = 0;
      tick;
   endtask
   task conclude;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #400000;
      failures++;
      conclude;
   end
   initial
   begin
      logic [13:0] a;
      logic [7:0] d, v, w;
      logic rc;
      int k, n;
      void'($urandom(57759));
      repeat (5) @(posedge clk_sys_i);
      #2;
      sys_rst_i = 0;
      chk("vmon_en", vmon_en_o, 1);
      chk("vmon_rst_en", vmon_rst_en_o, 1);
      chk("err_flag", flash_error_flag_o, 0);
      por_i = 1;
      tick;
      por_i = 0;
      tick;
      chk("por_flag", power_on_flag_o, 1);
      rd(FMG_ID_ADDR, d, rc);
      chk("id_byte", d, FMG_ID_DEFAULT);
      program_write_enable_i = 1;
      for (k = 0; k < 6; k++)
      begin
         a = (k == 0) ? 14'h01FF : 14'($urandom_range(16'h1FFF));
         v = 8'($urandom);
         w = 8'($urandom);
         page_erase_enable_i = 1;
         md(a, v, k == 1);
         page_erase_enable_i = 0;
         chk("erase_busy", 16'(nbusy), 16'(EC));
         chk("irq_in_busy", take_busy, 0);
         n = 0;
         while (k == 1 && irq_take_o !== 1'b1 && n < 4)
         begin
            n++;
            tick;
         end
         if (k == 1)
            chk("irq_after", irq_take_o, 1);
         rd(a ^ 14'h01FF, d, rc);
         chk("erased", d, FMG_ERASED);
         md(a, v, 0);
         chk("write_busy", 16'(nbusy), 1);
         md(a, w, 0);
         program_write_enable_i = 0;
         md(a, 8'h00, 0);
         program_write_enable_i = 1;
         rd(a, d, rc);
         chk("write_and", d, exp_and(v, w));
         if (k < 3)
         begin
            vm(k == 1, k == 2);
            md(a, 8'h00, 0);
            chk("err_reset", err_seen, 1);
            chk("err_flag_set", flash_error_flag_o, 1);
            rd(a, d, rc);
            chk("untouched", d, exp_and(v, w));
            vm(1, 1);
            flag_clr_i = 1;
            tick;
            flag_clr_i = 0;
            tick;
            chk("flag_clear", flash_error_flag_o, 0);
         end
      end
      rd(14'h0040, d, rc);
      rd(14'h0080, d, rc);
      chk("row_new", rc, 1);
      rd(14'h00BF, d, rc);
      chk("row_same", rc, 0);
      chk("one_shot", sense_en_o, 0);
      bypass_i = 1;
      tick;
      rd(14'h0100, d, rc);
      chk("bypass_hold", sense_en_o, 1);
      bypass_i = 0;
      tick;
      rd(14'h0101, d, rc);
      chk("one_shot_back", sense_en_o, 0);
      idle_req_i = 1;
      tick;
      idle_req_i = 0;
      tick;
      chk("idle_on", idle_o, 1);
      irq_i = 1;
      tick;
      irq_i = 0;
      repeat (3) tick;
      chk("idle_wake", idle_o, 0);
      conclude;
   end
endmodule
